// File: core/ucf_params.svh
// Offsets, field positions, reset values and counts of the clock control.
// Assumes a 16-bit plain register port with word addresses in steps of 4.
`ifndef UCF_PARAMS_SVH
`define UCF_PARAMS_SVH
// ==========================================================================
// Register offsets
`define UCF_OFS_FREQ 8'h00
`define UCF_OFS_USB 8'h04
`define UCF_OFS_WCNT 8'h08
`define UCF_OFS_WCSR 8'h0c
`define UCF_OFS_STAT 8'h10
// ==========================================================================
// Write keys in the upper byte
`define UCF_KEY_USB 8'ha5
`define UCF_KEY_WCNT 8'h5a
`define UCF_KEY_WCSR 8'ha5
// ==========================================================================
// Field positions
`define UCF_STC_LSB 8
`define UCF_IFC_LSB 4
`define UCF_PFC_LSB 0
`define UCF_USB_SRC_LSB 6
`define UCF_USB_OSC_BIT 5
`define UCF_WCSR_RUN_BIT 7
`define UCF_STAT_SETTLE_BIT 3
// ==========================================================================
// Reset values
`define UCF_RST_STC 2'h0
`define UCF_RST_IFC 2'h0
`define UCF_RST_PFC 2'h3
`define UCF_RST_USB_SRC 2'h3
`define UCF_RST_USB_OSC 1'h1
`define UCF_RST_WCNT 8'h00
`define UCF_RST_WCSR_CKS 3'h0
// ==========================================================================
// Mode with the external clock pin as input, count prescaler width
`define UCF_MODE_EXT_IN 3'h7
`define UCF_PRE_W 12
`endif

// File: core/ucf_pkg.sv
// Types shared by the clock control block.
// Assumes ucf_params.svh supplies the numeric constants.
package ucf_pkg;
  // Sequencer state: normal run or PLL settling pause
  typedef enum logic [0:0] {
    UCF_ST_RUN = 1'b0,
    UCF_ST_SETTLE = 1'b1
  } ucf_state_t;

  // Frequency settings travelling together
  typedef struct packed {
    logic [1:0] stc;
    logic [1:0] ifc;
    logic [1:0] pfc;
  } ucf_freq_t;

  // USB clock control contents
  typedef struct packed {
    logic [1:0] src;
    logic osc_run;
  } ucf_usb_t;
endpackage : ucf_pkg

// File: core/ucf_clk_div.sv
// Divide-by-1..4 tick generator for one derived clock enable.
// Assumes the code is stable except at clean update points.
`timescale 1ns/100ps
module ucf_clk_div (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Control
  input wire logic i_run,
  input wire logic [1:0] i_code,
  // Tick out
  output logic o_tick
);
  logic [1:0] cnt_reg;

  // Code n divides by n+1; count is cleared while stopped
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_reg <= 2'h0;
    end
    else if (!i_run)
    begin
      cnt_reg <= 2'h0;
    end
    else if (cnt_reg >= i_code)
    begin
      cnt_reg <= 2'h0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign o_tick = i_run && (cnt_reg >= i_code);
endmodule : ucf_clk_div

// File: core/ucf_wdt.sv
// Up counter with an eight-way prescaler, timing the PLL settling.
// Assumes load and run come from the register logic of the top.
`timescale 1ns/100ps
`include "ucf_params.svh"
module ucf_wdt (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Control
  input wire logic i_run,
  input wire logic [2:0] i_cks,
  input wire logic i_load,
  input wire logic [7:0] i_load_val,
  // State
  output logic [7:0] o_count,
  output logic o_ovf
);
  logic [`UCF_PRE_W-1:0] pre_reg;
  logic [`UCF_PRE_W-1:0] mask;
  logic step;

  // Division x1, 1/4, 1/16, 1/32, 1/64, 1/256, 1/1024, 1/4096
  always_comb
  begin
    case (i_cks)
      3'h0: mask = 12'h000;
      3'h1: mask = 12'h003;
      3'h2: mask = 12'h00f;
      3'h3: mask = 12'h01f;
      3'h4: mask = 12'h03f;
      3'h5: mask = 12'h0ff;
      3'h6: mask = 12'h3ff;
      default: mask = 12'hfff;
    endcase
  end

  assign step = i_run && ((pre_reg & mask) == mask); // RULE_17
  assign o_ovf = step && (o_count == 8'hff);

  // Prescaler restarts on load so the settling time starts clean
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pre_reg <= '0;
    else if (i_load)
      pre_reg <= '0;
    else if (i_run)
      pre_reg <= pre_reg + 12'h001;
  end

  // Counter itself; a load wins over a count step
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_count <= `UCF_RST_WCNT;
    else if (i_load)
      o_count <= i_load_val;
    else if (step)
      o_count <= o_count + 8'h01;
  end
endmodule : ucf_wdt

// File: core/ucf_clock_ctrl.sv
// Clock control: USB clock register, PLL rate and divider changes with a
// watchdog-timed settling pause, and mode pin capture at power-on.
// Assumes i_reset_n is the power-on reset; a manual reset never reaches
// this block, so every register here survives it.
//
// Overview of operation
// RULE_01: Software writes USB clock control as a word with key in upper byte.
// RULE_02: USB source select bits 7:6 reset to 11; 00 stops, 11 external.
// RULE_03: Bit 5 resets to 1 and runs the USB on-chip oscillator.
// RULE_04: Bits 4:0 of USB clock control read zero; software writes zero.
// RULE_05: Only power-on reset initialises USB clock control.
// RULE_06: Software should clear USB clock control when USB is unused.
// RULE_07: Software stops the USB function before changing USB clock control.
// RULE_08: Software runs USB only with peripheral clock above 13 MHz.
// RULE_09: Power-on gives rate one, core divider 00, peripheral divider 11.
// RULE_10: Software stops and preloads the watchdog before a rate change.
// RULE_11: Rate write starts change; dividers written with it apply at end.
// RULE_12: During settling the processor pauses, clocks stop, watchdog counts.
// RULE_13: Watchdog overflow releases new clocks, resumes processor, stops it.
// RULE_14: Divider-only writes never start the settling count.
// RULE_15: Divider-only changes apply at once; software picks legal codes.
// RULE_16: Mode pins are latched only at power-on reset.
// RULE_17: Watchdog counts on one of eight peripheral clock divisions; the code divides i_clk_sys, not the peripheral clock enable.
// RULE_18: Core divider codes 00..11 divide by one to four.
// RULE_19: Peripheral divider codes 00..11 divide by one to four, reset 11.
// RULE_20: Software loads the watchdog count as a word with its key.
// RULE_21: USB clock control ignores wrong-key or non-word writes.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "ucf_params.svh"
module ucf_clock_ctrl (
  // Clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_wr_word,
  input wire logic i_rd,
  output logic [15:0] o_rd_data,
  // Mode pins
  input wire logic [2:0] i_clock_mode_pins,
  // Clock control outputs
  output logic o_cpu_pause,
  output logic o_core_clk_en,
  output logic o_periph_clk_en,
  output logic o_ext_clk_out_en,
  output ucf_pkg::ucf_freq_t o_freq,
  output logic [2:0] o_clock_mode,
  // USB clock outputs
  output logic [1:0] o_usb_src_sel,
  output logic o_usb_osc_run
);
  // ========================================================================
  // Declarations
  ucf_pkg::ucf_state_t state_reg;
  ucf_pkg::ucf_state_t state_next;
  ucf_pkg::ucf_freq_t freq_reg;
  ucf_pkg::ucf_freq_t pend_reg;
  ucf_pkg::ucf_freq_t wr_freq;
  ucf_pkg::ucf_usb_t usb_reg;
  logic wdt_run_reg;
  logic [2:0] wdt_cks_reg;
  logic [2:0] mode_reg;
  logic mode_taken_reg;
  logic [15:0] rd_next;
  logic wr_freq_hit;
  logic wr_usb_hit;
  logic wr_wcnt_hit;
  logic wr_wcsr_hit;
  logic rate_change;
  logic wdt_count_en;
  logic [7:0] wdt_count;
  logic wdt_ovf;
  logic settle_done;
  logic [1:0] div_tick;
  logic [1:0] div_code [2];

  // ========================================================================
  // Write decode
  // Each keyed register accepts only a whole word with its own key above
  assign wr_freq_hit = i_wr && (i_addr == `UCF_OFS_FREQ)
    && (state_reg == ucf_pkg::UCF_ST_RUN);
  assign wr_usb_hit = i_wr && i_wr_word && (i_addr == `UCF_OFS_USB)
    && (i_wr_data[15:8] == `UCF_KEY_USB); // RULE_01 RULE_21
  assign wr_wcnt_hit = i_wr && i_wr_word && (i_addr == `UCF_OFS_WCNT)
    && (i_wr_data[15:8] == `UCF_KEY_WCNT); // RULE_20
  assign wr_wcsr_hit = i_wr && i_wr_word && (i_addr == `UCF_OFS_WCSR)
    && (i_wr_data[15:8] == `UCF_KEY_WCSR);

  // Field extraction from a frequency register write
  assign wr_freq.stc = i_wr_data[`UCF_STC_LSB+1:`UCF_STC_LSB];
  assign wr_freq.ifc = i_wr_data[`UCF_IFC_LSB+1:`UCF_IFC_LSB];
  assign wr_freq.pfc = i_wr_data[`UCF_PFC_LSB+1:`UCF_PFC_LSB];

  // Only a new multiplication rate needs the settling pause
  assign rate_change = wr_freq_hit && (wr_freq.stc != freq_reg.stc); // RULE_14

  // ========================================================================
  // Settling sequencer
  assign settle_done = (state_reg == ucf_pkg::UCF_ST_SETTLE) && wdt_ovf;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ucf_pkg::UCF_ST_RUN:
      begin
        if (rate_change)
          state_next = ucf_pkg::UCF_ST_SETTLE; // RULE_11
      end
      ucf_pkg::UCF_ST_SETTLE:
      begin
        if (wdt_ovf)
          state_next = ucf_pkg::UCF_ST_RUN; // RULE_13
      end
      default:
      begin
        state_next = ucf_pkg::UCF_ST_RUN;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_reg <= ucf_pkg::UCF_ST_RUN;
    else
      state_reg <= state_next;
  end

  // ========================================================================
  // Frequency settings
  // Rate and dividers written with it wait in pend_reg until the overflow,
  // so the core never sees a divider meant for a rate not yet running.
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pend_reg.stc <= `UCF_RST_STC;
      pend_reg.ifc <= `UCF_RST_IFC;
      pend_reg.pfc <= `UCF_RST_PFC;
    end
    else if (rate_change)
    begin
      pend_reg <= wr_freq; // RULE_11
    end
  end

  // Active settings
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      freq_reg.stc <= `UCF_RST_STC; // RULE_09
      freq_reg.ifc <= `UCF_RST_IFC; // RULE_09
      freq_reg.pfc <= `UCF_RST_PFC; // RULE_09 RULE_19
    end
    else if (settle_done)
    begin
      freq_reg <= pend_reg; // RULE_13
    end
    else if (wr_freq_hit && !rate_change)
    begin
      freq_reg.ifc <= wr_freq.ifc; // RULE_15
      freq_reg.pfc <= wr_freq.pfc; // RULE_15
    end
  end

  // ========================================================================
  // Watchdog control
  // Run bit is software's outside a pause; the overflow clears it so the
  // counter stops after releasing the clocks.
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wdt_run_reg <= 1'b0;
      wdt_cks_reg <= `UCF_RST_WCSR_CKS;
    end
    else if (settle_done)
    begin
      wdt_run_reg <= 1'b0; // RULE_13
    end
    else if (wr_wcsr_hit)
    begin
      wdt_run_reg <= i_wr_data[`UCF_WCSR_RUN_BIT];
      wdt_cks_reg <= i_wr_data[2:0];
    end
  end

  // Count while enabled or while timing a settling pause
  assign wdt_count_en = wdt_run_reg
    || (state_reg == ucf_pkg::UCF_ST_SETTLE); // RULE_12

  ucf_wdt u_wdt (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_run(wdt_count_en),
    .i_cks(wdt_cks_reg),
    .i_load(wr_wcnt_hit),
    .i_load_val(i_wr_data[7:0]),
    .o_count(wdt_count),
    .o_ovf(wdt_ovf)
  );

  // ========================================================================
  // Clock dividers
  // Both derived enables come from one divider shape; stopped in a pause
  assign div_code[0] = freq_reg.ifc;
  assign div_code[1] = freq_reg.pfc;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_div
      ucf_clk_div u_div (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_run(state_next == ucf_pkg::UCF_ST_RUN), // RULE_12
        .i_code(div_code[gi]), // RULE_18 RULE_19
        .o_tick(div_tick[gi])
      );
    end
  endgenerate

  // Clock enables and processor pause, registered for clean outputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cpu_pause <= 1'b0;
      o_core_clk_en <= 1'b0;
      o_periph_clk_en <= 1'b0;
    end
    else
    begin
      o_cpu_pause <= (state_next == ucf_pkg::UCF_ST_SETTLE); // RULE_12
      o_core_clk_en <= div_tick[0]; // RULE_12
      o_periph_clk_en <= div_tick[1]; // RULE_12
    end
  end

  // ========================================================================
  // Mode pin capture
  // Caught once at the first edge after power-on release, then frozen
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_reg <= 3'h0;
      mode_taken_reg <= 1'b0;
    end
    else if (!mode_taken_reg)
    begin
      mode_reg <= i_clock_mode_pins; // RULE_16
      mode_taken_reg <= 1'b1;
    end
  end

  // External clock pin keeps driving through a pause, except when it is
  // an input in the externally clocked mode
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_ext_clk_out_en <= 1'b0;
    else
      o_ext_clk_out_en <= mode_taken_reg
        && (mode_reg != `UCF_MODE_EXT_IN); // RULE_12
  end

  // ========================================================================
  // USB clock control
  // Held through manual reset; only the power-on reset touches it
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      usb_reg.src <= `UCF_RST_USB_SRC; // RULE_02 RULE_05
      usb_reg.osc_run <= `UCF_RST_USB_OSC; // RULE_03 RULE_05
    end
    else if (wr_usb_hit)
    begin
      usb_reg.src <= i_wr_data[`UCF_USB_SRC_LSB+1:`UCF_USB_SRC_LSB];
      usb_reg.osc_run <= i_wr_data[`UCF_USB_OSC_BIT]; // RULE_03
    end
  end

  // Prohibited source codes stop the clock rather than pick a source
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_usb_src_sel <= `UCF_RST_USB_SRC;
      o_usb_osc_run <= `UCF_RST_USB_OSC;
    end
    else
    begin
      o_usb_src_sel <= (usb_reg.src == 2'h3) ? 2'h3 : 2'h0; // RULE_02
      o_usb_osc_run <= usb_reg.osc_run; // RULE_03
    end
  end

  // ========================================================================
  // Status outputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_freq.stc <= `UCF_RST_STC;
      o_freq.ifc <= `UCF_RST_IFC;
      o_freq.pfc <= `UCF_RST_PFC;
      o_clock_mode <= 3'h0;
    end
    else
    begin
      o_freq <= freq_reg;
      o_clock_mode <= mode_reg;
    end
  end

  // ========================================================================
  // Read mux
  // Unmapped addresses read zero; reserved bits are never stored
  always_comb
  begin
    rd_next = 16'h0000;
    case (i_addr)
      `UCF_OFS_FREQ:
      begin
        rd_next[`UCF_STC_LSB+1:`UCF_STC_LSB] = freq_reg.stc;
        rd_next[`UCF_IFC_LSB+1:`UCF_IFC_LSB] = freq_reg.ifc;
        rd_next[`UCF_PFC_LSB+1:`UCF_PFC_LSB] = freq_reg.pfc;
      end
      `UCF_OFS_USB:
      begin
        rd_next[`UCF_USB_SRC_LSB+1:`UCF_USB_SRC_LSB] = usb_reg.src;
        rd_next[`UCF_USB_OSC_BIT] = usb_reg.osc_run; // RULE_04
      end
      `UCF_OFS_WCNT:
        rd_next[7:0] = wdt_count;
      `UCF_OFS_WCSR:
      begin
        rd_next[`UCF_WCSR_RUN_BIT] = wdt_run_reg;
        rd_next[2:0] = wdt_cks_reg;
      end
      `UCF_OFS_STAT:
      begin
        rd_next[2:0] = mode_reg;
        rd_next[`UCF_STAT_SETTLE_BIT] =
          (state_reg == ucf_pkg::UCF_ST_SETTLE);
      end
      default:
        rd_next = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rd_data <= 16'h0000;
    else if (i_rd)
      o_rd_data <= rd_next;
    else
      o_rd_data <= 16'h0000;
  end
endmodule : ucf_clock_ctrl

// File: tb/ucf_clock_ctrl_properties.sv
// Port-level checks of the clock control block.
// Assumes one clock domain and the power-on reset only.
`timescale 1ns/100ps
`include "ucf_params.svh"
module ucf_clock_ctrl_properties (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_wr_word,
  input wire logic i_rd,
  input wire logic [15:0] o_rd_data,
  // Watched outputs
  input wire logic o_cpu_pause,
  input wire logic o_core_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_ext_clk_out_en,
  input wire ucf_pkg::ucf_freq_t o_freq,
  input wire logic [2:0] o_clock_mode,
  input wire logic [1:0] o_usb_src_sel,
  input wire logic o_usb_osc_run
);
  // ==========================================================================
  // Helpers
  logic [1:0] up_cnt_reg;
  wire freq_wr = i_wr && (i_addr == `UCF_OFS_FREQ) && !o_cpu_pause;
  wire same_stc = (i_wr_data[9:8] == o_freq.stc);
  wire usb_wr = i_wr && (i_addr == `UCF_OFS_USB);
  wire usb_key = i_wr_word && (i_wr_data[15:8] == `UCF_KEY_USB);
  // Edges since reset; mode output is settled by the third
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
    if (!i_reset_n)
      up_cnt_reg <= 2'h0;
    else if (up_cnt_reg != 2'h3)
      up_cnt_reg <= up_cnt_reg + 2'h1;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // ==========================================================================
  // Assertions
  chk_pause_gates_clk: assert property (
    o_cpu_pause |-> !o_core_clk_en && !o_periph_clk_en)
    else $error("clock enable seen during pause");
  chk_pause_keeps_ext: assert property (
    o_cpu_pause && o_clock_mode != `UCF_MODE_EXT_IN |-> o_ext_clk_out_en)
    else $error("external clock dropped during pause");
  chk_rate_pauses: assert property (
    freq_wr && !same_stc |=> o_cpu_pause)
    else $error("rate write did not pause");
  chk_div_no_pause: assert property (
    freq_wr && same_stc |=> !o_cpu_pause [*3])
    else $error("divider write paused");
  chk_div_at_once: assert property (
    freq_wr && same_stc |-> ##2 o_freq ==
      $past({i_wr_data[9:8], i_wr_data[5:4], i_wr_data[1:0]}, 2))
    else $error("divider write not applied");
  chk_freq_held: assert property (
    o_cpu_pause |-> $stable(o_freq))
    else $error("settings moved during pause");
  chk_stc_at_end: assert property (
    $changed(o_freq.stc) |-> $past(o_cpu_pause, 2) && !$past(o_cpu_pause))
    else $error("rate changed outside pause end");
  chk_mode_latched: assert property (
    up_cnt_reg == 2'h3 |-> $stable(o_clock_mode))
    else $error("mode changed after reset");
  chk_usb_low_zero: assert property (
    i_rd && i_addr == `UCF_OFS_USB
      |=> {o_rd_data[15:8], o_rd_data[4:0]} == 13'h0000)
    else $error("usb reserved bits not zero");
  chk_usb_refused: assert property (
    usb_wr && !usb_key |-> ##2 $stable({o_usb_src_sel, o_usb_osc_run}))
    else $error("unkeyed usb write took effect");
  chk_usb_osc: assert property (
    usb_wr && usb_key |-> ##2 o_usb_osc_run == $past(i_wr_data[5], 2))
    else $error("usb oscillator run wrong");
  chk_usb_src: assert property (
    usb_wr && usb_key && i_wr_data[7] == i_wr_data[6]
      |-> ##2 o_usb_src_sel == $past(i_wr_data[7:6], 2))
    else $error("usb source select wrong");
  // Main scenarios reached
  cov_rate: cover property (freq_wr && !same_stc);
  cov_release: cover property ($fell(o_cpu_pause));
  cov_usb_refused: cover property (usb_wr && !usb_key);
endmodule : ucf_clock_ctrl_properties

bind ucf_clock_ctrl ucf_clock_ctrl_properties u_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr(i_wr), .i_wr_word(i_wr_word),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .o_cpu_pause(o_cpu_pause),
  .o_core_clk_en(o_core_clk_en), .o_periph_clk_en(o_periph_clk_en),
  .o_ext_clk_out_en(o_ext_clk_out_en), .o_freq(o_freq),
  .o_clock_mode(o_clock_mode), .o_usb_src_sel(o_usb_src_sel),
  .o_usb_osc_run(o_usb_osc_run)
);

// File: tb/ucf_sw_model.sv
// Software side: register accesses on the plain port of the block.
// Assumes read data stand in the cycle after the read strobe only.
`timescale 1ns/100ps
`include "ucf_params.svh"
module ucf_sw_model (
  // Clock
  input wire logic i_clk_sys,
  // Register port towards the block
  output logic [7:0] o_addr,
  output logic [15:0] o_wr_data,
  output logic o_wr,
  output logic o_wr_word,
  output logic o_rd,
  input wire logic [15:0] i_rd_data
);
  // Idle bus at time zero
  initial
  begin
    o_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_wr = 1'b0;
    o_wr_word = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write; data scrambled afterwards so no stale value lingers
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d,
    input logic word);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wr_data <= d;
    o_wr_word <= word;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wr_data <= ~d;
  endtask : write_reg
  // One-cycle read; data taken in the following cycle
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    #1;
    d = i_rd_data;
  endtask : read_reg
  // Keyed word write; caller has stopped the USB function first
  task automatic usb_write(input logic [2:0] top);
    write_reg(`UCF_OFS_USB, {`UCF_KEY_USB, top, 5'h00}, 1'b1);
  endtask : usb_write
  // Stop the counter, pick its clock, preload the settling count
  task automatic wdt_prepare(input logic [2:0] cks, input logic [7:0] cnt);
    write_reg(`UCF_OFS_WCSR, {`UCF_KEY_WCSR, 5'h00, cks}, 1'b1);
    write_reg(`UCF_OFS_WCNT, {`UCF_KEY_WCNT, cnt}, 1'b1);
  endtask : wdt_prepare
endmodule : ucf_sw_model

// File: tb/ucf_clock_ctrl_bench.sv
// Self-checking bench of the clock control block.
// Assumes the software model drives the register port.
`timescale 1ns/100ps
`include "ucf_params.svh"
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module ucf_clock_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode_pins = 3'h5;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data, rv;
  logic wr, wr_word, rd, pause, core_en, per_en, ext_en, usb_osc;
  logic [1:0] usb_src;
  logic [2:0] mode;
  ucf_pkg::ucf_freq_t freq;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  // 100 MHz, well above the USB minimum peripheral rate
  always #5 clk_sys = ~clk_sys;
  ucf_sw_model sw (.i_clk_sys(clk_sys), .o_addr(addr), .o_wr_data(wr_data),
    .o_wr(wr), .o_wr_word(wr_word), .o_rd(rd), .i_rd_data(rd_data));
  ucf_clock_ctrl dut (.i_clk_sys(clk_sys), .i_reset_n(rst_n),
    .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_wr_word(wr_word),
    .i_rd(rd), .o_rd_data(rd_data), .i_clock_mode_pins(mode_pins),
    .o_cpu_pause(pause), .o_core_clk_en(core_en),
    .o_periph_clk_en(per_en), .o_ext_clk_out_en(ext_en), .o_freq(freq),
    .o_clock_mode(mode), .o_usb_src_sel(usb_src), .o_usb_osc_run(usb_osc));
  // ==========================================================================
  // Helpers
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  // Cycles between two ticks of one enable
  task automatic tick_gap(input logic sel, output int gap);
    int first;
    first = -1;
    gap = 0;
    for (int k = 0; k < 40 && gap == 0; k++)
    begin
      @(posedge clk_sys);
      #1;
      if ((sel ? per_en : core_en) === 1'b1)
        if (first >= 0)
          gap = k - first;
        else
          first = k;
    end
  endtask : tick_gap
  // Cycles the pause stands after a rate write; a hang ends the run
  task automatic pause_len(output int len);
    len = 0;
    #1;
    while (pause === 1'b1 && len < 100)
    begin
      @(posedge clk_sys);
      #1;
      len++;
    end
    if (len >= 100)
    begin
      num_errors++;
      conclude();
    end
  endtask : pause_len
  // ==========================================================================
  // Scenarios
  task automatic test_reset(input logic [2:0] pins);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    mode_pins <= pins;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("freq", 6'h03, freq)
    `CHK("src", 2'h3, usb_src)
    `CHK("osc", 1'b1, usb_osc)
    `CHK("ext", pins != 3'h7, ext_en)
    sw.read_reg(`UCF_OFS_USB, rv);
    `CHK("usb rd", 16'h00e0, rv)
    @(posedge clk_sys);
    mode_pins <= ~pins;
    settle();
    `CHK("mode", pins, mode)
    sw.read_reg(`UCF_OFS_STAT, rv);
    `CHK("stat mode", pins, rv[2:0])
  endtask : test_reset
  task automatic test_usb;
    sw.write_reg(`UCF_OFS_USB, 16'h5a00, 1'b1);
    sw.write_reg(`UCF_OFS_USB, 16'ha500, 1'b0);
    settle();
    `CHK("usb kept", 3'h7, {usb_src, usb_osc})
    sw.usb_write(3'h0);
    settle();
    `CHK("usb off", 3'h0, {usb_src, usb_osc})
    sw.usb_write(3'h1);
    settle();
    `CHK("osc on", 3'h1, {usb_src, usb_osc})
    sw.usb_write(3'h6);
    settle();
    `CHK("ext src", 3'h6, {usb_src, usb_osc})
    sw.read_reg(`UCF_OFS_USB, rv);
    `CHK("usb rd", 16'h00c0, rv)
    sw.usb_write(3'h2);
    settle();
    `CHK("bad src", 3'h0, {usb_src, usb_osc})
    sw.read_reg(`UCF_OFS_USB, rv);
    `CHK("bad rd", 16'h0040, rv)
  endtask : test_usb
  task automatic test_divide;
    for (int c = 0; c < 4; c++)
    begin
      sw.write_reg(`UCF_OFS_FREQ, 16'(c * 16 + c), 1'b1);
      settle();
      `CHK("no pause", 1'b0, pause)
      `CHK("div", {2'h0, 2'(c), 2'(c)}, freq)
      tick_gap(1'b0, n);
      `CHK("core gap", c + 1, n)
      tick_gap(1'b1, n);
      `CHK("per gap", c + 1, n)
    end
  endtask : test_divide
  task automatic test_rate;
    sw.wdt_prepare(3'h0, 8'hf0);
    sw.write_reg(`UCF_OFS_FREQ, 16'h0312, 1'b1);
    pause_len(n);
    `CHK("pause x1", 16, n)
    settle();
    `CHK("new freq", 6'h36, freq)
    sw.read_reg(`UCF_OFS_WCSR, rv);
    `CHK("wdt stop", 1'b0, rv[7])
    sw.read_reg(`UCF_OFS_WCNT, rv);
    `CHK("wdt held", 16'h0000, rv)
    sw.wdt_prepare(3'h1, 8'hf8);
    sw.write_reg(`UCF_OFS_FREQ, 16'h0003, 1'b1);
    pause_len(n);
    `CHK("pause x4", 32, n)
    settle();
    `CHK("back freq", 6'h03, freq)
  endtask : test_rate
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Main sequence, second power-on with other mode pins
  initial
  begin
    test_reset(3'h5);
    test_usb();
    test_divide();
    test_rate();
    test_reset(3'h7);
    conclude();
  end
endmodule : ucf_clock_ctrl_bench
